// ==== inc/cid_params.svh ====
// Constants for the command input dispatcher
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH
`define CID_NUM_IN        4
`define CID_NUM_OUT       2
`define CID_FN_DIFF_CLR   4'h1
`define CID_FN_DIRECTION  4'h3
`define CID_FN_EDGE_NUDGE 4'h5
`define CID_FN_NUDGE_UP   4'h7
`define CID_FN_NUDGE_DOWN 4'h8
`define CID_FN_HOLD_ZERO  4'hb
`define CID_CODE_HOLD_ZERO  8'h36
`define CID_CODE_DIRECTION  8'h3a
`define CID_CODE_DIFF_CLR   8'h3c
`define CID_CODE_EDGE_NUDGE 8'h3d
`define CID_CODE_NUDGE_UP   8'h41
`define CID_CODE_NUDGE_DOWN 8'h42
`define CID_ADDR_DIRECTION  16'hff00
`define CID_ADDR_HOLD_ZERO  16'hff02
`define CID_ADDR_DIFF_CLR   16'hff04
`define CID_ADDR_EDGE_NUDGE 16'hff0a
`define CID_ADDR_NUDGE_UP   16'hff0c
`define CID_ADDR_NUDGE_DOWN 16'hff0e
`define CID_ADDR_IN_STATE   16'hff20
`define CID_ADDR_TALLY      16'hff22
`define CID_ADDR_DIFF_CNT   16'hff24
`define CID_ADDR_NUDGE_IVL  16'hff26
`define CID_ADDR_NUDGE_CNT  16'hff28
`define CID_ADDR_CFG        16'hff2a
`define CID_ADDR_IN_FN      16'hff2c
`define CID_ADDR_OUT_SRC    16'hff2e
`define CID_TALLY_POS       8'h04
`define CID_SRC_DIRECTION   4'h3
`define CID_SRC_HOLD_ZERO   4'h4
`define CID_LOOP_NS         1000
`define CID_CLK_NS          5
`define CID_LOOP_CYC        ((`CID_LOOP_NS + `CID_CLK_NS - 1) / `CID_CLK_NS)
`endif

// ==== inc/cid_pkg.sv ====
// Types for the command input dispatcher
package cid_pkg;
  typedef enum logic [1:0] {
    CID_IDLE  = 2'b00,
    CID_WRITE = 2'b01,
    CID_READ  = 2'b11,
    CID_WAIT  = 2'b10
  } cid_host_state_t;
  typedef struct packed {
    logic hold_zero;
    logic direction;
    logic diff_clr;
    logic edge_nudge;
    logic nudge_up;
    logic nudge_down;
  } cid_cmd_t;
endpackage

// ==== inc/cid_if.sv ====
// Register link between controller and dispatcher
`timescale 1ns/1ps
`default_nettype none
interface cid_if;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [7:0]  code;
  logic        code_val;
  logic        code_wr;
  modport dev  (input addr, wdata, wr, rd, code, code_val, code_wr, output rdata);
  modport host (output addr, wdata, wr, rd, code, code_val, code_wr, input rdata);
endinterface
`default_nettype wire

// ==== verilog/cid_sync.sv ====
// Two-flop synchroniser bank for control inputs
`timescale 1ns/1ps
`default_nettype none
module cid_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_reg[g] <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          meta_reg[g] <= async_in[g];
          sync_out[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule // cid_sync
`default_nettype wire

// ==== verilog/cid_device.sv ====
// Command dispatcher: control inputs and register commands to command flags
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cid_params.svh"
module cid_device
  import cid_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  cid_if.dev                          bus,
  input  wire logic [`CID_NUM_IN-1:0] ctrl_in,
  output logic                        freq_zero,
  output logic                        phase_reverse,
  output logic                        ref_clear,
  output logic                        jog_clear,
  output logic [`CID_NUM_OUT-1:0]     ctrl_out
);
  logic [`CID_NUM_IN-1:0] in_sync;
  logic [15:0]            tally_reg;
  logic [15:0]            diff_cnt_reg;
  logic [15:0]            nudge_ivl_reg;
  logic [15:0]            nudge_cnt_reg;
  logic [15:0]            cfg_reg;
  logic [15:0]            in_fn_reg;
  logic [7:0]             out_src_reg;
  logic [15:0]            rdata_reg;
  cid_cmd_t               sw_reg;
  cid_cmd_t               cmd;
  cid_cmd_t               cmd_prev_reg;
  logic [15:0]            loop_cnt_reg;
  logic [15:0]            ivl_cnt_reg;
  logic                   loop_tick;
  logic                   trim_step;
  logic [`CID_NUM_IN-1:0] in_active;

  cid_sync #(.W(`CID_NUM_IN)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (ctrl_in),
    .sync_out (in_sync)
  );

  // Any input assigned to the given function and active
  function automatic logic fn_hit(input logic [`CID_NUM_IN-1:0] act,
                                  input logic [15:0] fns, input logic [3:0] fn);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `CID_NUM_IN; i++) begin
      if (act[i] && fns[i*4 +: 4] == fn) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // Output source decode with inversion
  function automatic logic out_drive(input logic [3:0] src, input logic inv,
                                     input cid_cmd_t c);
    logic v;
    v = 1'b0;
    if (src == `CID_SRC_HOLD_ZERO) begin
      v = c.hold_zero;
    end else if (src == `CID_SRC_DIRECTION) begin
      v = c.direction;
    end
    return v ^ inv;
  endfunction

  // Polarity: cfg bit i selects active-high input i
  assign in_active = in_sync ~^ cfg_reg[`CID_NUM_IN-1:0];

  always_comb begin
    cmd.hold_zero  = sw_reg.hold_zero  | fn_hit(in_active, in_fn_reg, `CID_FN_HOLD_ZERO);
    cmd.direction  = sw_reg.direction  | fn_hit(in_active, in_fn_reg, `CID_FN_DIRECTION);
    cmd.diff_clr   = sw_reg.diff_clr   | fn_hit(in_active, in_fn_reg, `CID_FN_DIFF_CLR);
    cmd.edge_nudge = sw_reg.edge_nudge | fn_hit(in_active, in_fn_reg, `CID_FN_EDGE_NUDGE);
    cmd.nudge_up   = sw_reg.nudge_up   | fn_hit(in_active, in_fn_reg, `CID_FN_NUDGE_UP);
    cmd.nudge_down = sw_reg.nudge_down | fn_hit(in_active, in_fn_reg, `CID_FN_NUDGE_DOWN);
  end

  // Software command flags from register or code writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_reg <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        `CID_ADDR_HOLD_ZERO:  sw_reg.hold_zero  <= bus.wdata[0];
        `CID_ADDR_DIRECTION:  sw_reg.direction  <= bus.wdata[0];
        `CID_ADDR_DIFF_CLR:   sw_reg.diff_clr   <= bus.wdata[0];
        `CID_ADDR_EDGE_NUDGE: sw_reg.edge_nudge <= bus.wdata[0];
        `CID_ADDR_NUDGE_UP:   sw_reg.nudge_up   <= bus.wdata[0];
        `CID_ADDR_NUDGE_DOWN: sw_reg.nudge_down <= bus.wdata[0];
        default: ;
      endcase
    end else if (bus.code_wr) begin
      case (bus.code)
        `CID_CODE_HOLD_ZERO:  sw_reg.hold_zero  <= bus.code_val;
        `CID_CODE_DIRECTION:  sw_reg.direction  <= bus.code_val;
        `CID_CODE_DIFF_CLR:   sw_reg.diff_clr   <= bus.code_val;
        `CID_CODE_EDGE_NUDGE: sw_reg.edge_nudge <= bus.code_val;
        `CID_CODE_NUDGE_UP:   sw_reg.nudge_up   <= bus.code_val;
        `CID_CODE_NUDGE_DOWN: sw_reg.nudge_down <= bus.code_val;
        default: ;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nudge_ivl_reg <= '0;
      nudge_cnt_reg <= 16'h0001;
      cfg_reg       <= '0;
      in_fn_reg     <= '0;
      out_src_reg   <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        `CID_ADDR_NUDGE_IVL: nudge_ivl_reg <= bus.wdata;
        `CID_ADDR_NUDGE_CNT: nudge_cnt_reg <= bus.wdata;
        `CID_ADDR_CFG:       cfg_reg       <= bus.wdata;
        `CID_ADDR_IN_FN:     in_fn_reg     <= bus.wdata;
        `CID_ADDR_OUT_SRC:   out_src_reg   <= bus.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Control loop tick
  assign loop_tick = (loop_cnt_reg == 16'(`CID_LOOP_CYC - 1));
  always_ff @(posedge clk) begin
    if (sys_rst || loop_tick) begin
      loop_cnt_reg <= '0;
    end else begin
      loop_cnt_reg <= loop_cnt_reg + 16'h0001;
    end
  end

  // Trim spacing in loop iterations
  // Exactly one trim direction active, else no step at all
  assign trim_step = loop_tick && (cmd.nudge_up ^ cmd.nudge_down)
                     && (ivl_cnt_reg >= nudge_ivl_reg);
  always_ff @(posedge clk) begin
    if (sys_rst || !(cmd.nudge_up ^ cmd.nudge_down)) begin
      ivl_cnt_reg <= '0;
    end else if (loop_tick) begin
      ivl_cnt_reg <= trim_step ? 16'h0000 : ivl_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_prev_reg <= '0;
    end else begin
      cmd_prev_reg <= cmd;
    end
  end

  // Differential counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      diff_cnt_reg <= '0;
    end else if (cmd.diff_clr && !cmd_prev_reg.diff_clr) begin
      diff_cnt_reg <= '0;
    end else if (!cmd.edge_nudge && cmd_prev_reg.edge_nudge) begin
      diff_cnt_reg <= diff_cnt_reg + nudge_cnt_reg;
    end else if (trim_step) begin
      diff_cnt_reg <= cmd.nudge_up ? diff_cnt_reg + 16'h0001
                                   : diff_cnt_reg - 16'h0001;
    end
  end

  // Trim tally
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tally_reg <= '0;
    end else if (cmd.diff_clr && !cmd_prev_reg.diff_clr && cfg_reg[8]) begin
      tally_reg <= '0;
    end else if (trim_step) begin
      tally_reg <= cmd.nudge_up ? tally_reg + 16'h0001 : tally_reg - 16'h0001;
    end
  end

  // Read port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        `CID_ADDR_IN_STATE:   rdata_reg <= {12'h000, in_sync};
        `CID_ADDR_TALLY:      rdata_reg <= tally_reg;
        `CID_ADDR_DIFF_CNT:   rdata_reg <= diff_cnt_reg;
        `CID_ADDR_NUDGE_IVL:  rdata_reg <= nudge_ivl_reg;
        `CID_ADDR_NUDGE_CNT:  rdata_reg <= nudge_cnt_reg;
        `CID_ADDR_CFG:        rdata_reg <= cfg_reg;
        `CID_ADDR_IN_FN:      rdata_reg <= in_fn_reg;
        `CID_ADDR_OUT_SRC:    rdata_reg <= {8'h00, out_src_reg};
        `CID_ADDR_HOLD_ZERO:  rdata_reg <= {15'h0000, cmd.hold_zero};
        `CID_ADDR_DIRECTION:  rdata_reg <= {15'h0000, cmd.direction};
        `CID_ADDR_DIFF_CLR:   rdata_reg <= {15'h0000, cmd.diff_clr};
        `CID_ADDR_EDGE_NUDGE: rdata_reg <= {15'h0000, cmd.edge_nudge};
        `CID_ADDR_NUDGE_UP:   rdata_reg <= {15'h0000, cmd.nudge_up};
        `CID_ADDR_NUDGE_DOWN: rdata_reg <= {15'h0000, cmd.nudge_down};
        default:              rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end
  assign bus.rdata = rdata_reg;

  // Command outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      freq_zero     <= 1'b0;
      phase_reverse <= 1'b0;
      ref_clear     <= 1'b0;
      jog_clear     <= 1'b0;
    end else begin
      freq_zero     <= cmd.hold_zero;
      phase_reverse <= cmd.direction;
      ref_clear     <= cmd.hold_zero && !cmd_prev_reg.hold_zero;
      jog_clear     <= cmd.hold_zero && !cmd_prev_reg.hold_zero;
    end
  end

  genvar k;
  generate
    for (k = 0; k < `CID_NUM_OUT; k++) begin : g_out
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ctrl_out[k] <= 1'b0;
        end else begin
          ctrl_out[k] <= out_drive(out_src_reg[k*4 +: 4], cfg_reg[12+k], cmd);
        end
      end
    end
  endgenerate
endmodule // cid_device
`default_nettype wire

// ==== verilog/cid_host.sv ====
// Controller end: software port onto the dispatcher link
`timescale 1ns/1ps
`default_nettype none
`include "cid_params.svh"
module cid_host
  import cid_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  cid_if.host              bus,
  input  wire logic [15:0] sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  input  wire logic [7:0]  sw_code,
  input  wire logic        sw_code_val,
  input  wire logic        sw_code_wr,
  output logic      [15:0] sw_rdata
);
  cid_host_state_t state_reg;
  // Forward each strobe one cycle later, code_wr only without sw_wr; data ready two cycles after read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.addr     <= '0;
      bus.wdata    <= '0;
      bus.wr       <= 1'b0;
      bus.rd       <= 1'b0;
      bus.code     <= '0;
      bus.code_val <= 1'b0;
      bus.code_wr  <= 1'b0;
    end else begin
      bus.addr     <= sw_addr;
      bus.wdata    <= sw_wdata;
      bus.wr       <= sw_wr;
      bus.rd       <= sw_rd;
      bus.code     <= sw_code;
      bus.code_val <= sw_code_val;
      bus.code_wr  <= sw_code_wr && !sw_wr;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= CID_IDLE;
    end else begin
      case (state_reg)
        CID_IDLE:  state_reg <= sw_rd ? CID_READ : (sw_wr ? CID_WRITE : CID_IDLE);
        CID_WRITE: state_reg <= sw_rd ? CID_READ : (sw_wr ? CID_WRITE : CID_IDLE);
        CID_READ:  state_reg <= sw_rd ? CID_WAIT : (sw_wr ? CID_WRITE : CID_WAIT);
        CID_WAIT:  state_reg <= sw_rd ? CID_READ : (sw_wr ? CID_WRITE : CID_IDLE);
        default:   state_reg <= CID_IDLE;
      endcase
    end
  end
  assign sw_rdata = (state_reg == CID_WAIT) ? bus.rdata : 16'h0000;
endmodule // cid_host
`default_nettype wire

// ==== verif/cid_link_monitor.sv ====
// Assertion checker on the dispatcher link and command flags
`timescale 1ns/1ps
`default_nettype none
module cid_link_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [7:0]  code,
  input wire logic        code_val,
  input wire logic        code_wr,
  input wire logic        freq_zero,
  input wire logic        phase_reverse,
  input wire logic        ref_clear,
  input wire logic        jog_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobes together");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  hold_write_a: assert property (wr && addr == 16'hff02 && wdata[0] |-> ##[1:3] freq_zero)
    else $error("hold write did not force zero frequency");
  dir_write_a: assert property (wr && addr == 16'hff00 && wdata[0] |-> ##[1:3] phase_reverse)
    else $error("direction write did not reverse phase");
  hold_code_a: assert property (code_wr && !wr && code_val && code == 8'h36
    |-> ##[1:3] freq_zero)
    else $error("hold code did not force zero frequency");
  dir_code_a: assert property (code_wr && !wr && code_val && code == 8'h3a
    |-> ##[1:3] phase_reverse)
    else $error("direction code did not reverse phase");
  clear_on_hold_a: assert property ($rose(freq_zero) |-> ##[0:1] (ref_clear || $past(ref_clear)))
    else $error("no pending clear pulse at hold");
  clear_pulse_a: assert property (ref_clear |=> !ref_clear)
    else $error("clear pulse longer than one cycle");
  clears_paired_a: assert property (ref_clear == jog_clear)
    else $error("reference and jog clears differ");
endmodule // cid_link_monitor
`default_nettype wire

// ==== verif/cid_tb.sv ====
// Self-checking bench for the dispatcher and its controller end
`timescale 1ns/1ps
`default_nettype none
module cid_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] sw_addr = 16'h0000;
  logic [15:0] sw_wdata = 16'h0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [7:0]  sw_code = 8'h00;
  logic        sw_code_val = 1'b0;
  logic        sw_code_wr = 1'b0;
  logic [3:0]  ctrl_in = 4'hf;
  logic [15:0] sw_rdata;
  logic        freq_zero, phase_reverse, ref_clear, jog_clear;
  logic [1:0]  ctrl_out;
  logic [15:0] v, t0, d0;
  logic [15:0] adr [5] = '{16'hff00, 16'hff02, 16'hff0a, 16'hff0c, 16'hff0e};
  logic [7:0]  cod [5] = '{8'h3a, 8'h36, 8'h3d, 8'h41, 8'h42};
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_clr = 0;
  wire logic [15:0] fl = {12'h000, ctrl_out, phase_reverse, freq_zero};
  always #2.5 clk = ~clk;
  cid_if i_cid_if ();
  cid_host i_cid_host (.clk(clk), .sys_rst(sys_rst), .bus(i_cid_if.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_code(sw_code),
    .sw_code_val(sw_code_val), .sw_code_wr(sw_code_wr), .sw_rdata(sw_rdata));
  cid_device i_cid_device (.clk(clk), .sys_rst(sys_rst), .bus(i_cid_if.dev), .ctrl_in(ctrl_in),
    .freq_zero(freq_zero), .phase_reverse(phase_reverse), .ref_clear(ref_clear),
    .jog_clear(jog_clear), .ctrl_out(ctrl_out));
  cid_link_monitor i_cid_link_monitor (.clk(clk), .sys_rst(sys_rst), .addr(i_cid_if.addr),
    .wdata(i_cid_if.wdata), .wr(i_cid_if.wr), .rd(i_cid_if.rd), .rdata(i_cid_if.rdata),
    .code(i_cid_if.code), .code_val(i_cid_if.code_val), .code_wr(i_cid_if.code_wr),
    .freq_zero(freq_zero), .phase_reverse(phase_reverse), .ref_clear(ref_clear),
    .jog_clear(jog_clear));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      stop_test;
    end
  end
  // Count paired reference and jog clear pulses
  always @(posedge clk) begin
    if (ref_clear && jog_clear) begin
      n_clr++;
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input logic [15:0] g, input logic [15:0] lo,
                     input logic [15:0] hi);
    n_tests++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic wcode(input logic [7:0] c, input logic b);
    @(posedge clk);
    sw_code <= c;
    sw_code_val <= b;
    sw_code_wr <= 1'b1;
    @(posedge clk);
    sw_code_wr <= 1'b0;
  endtask
  task automatic rd16(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(posedge clk);
    #1 d = sw_rdata;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd16(a, d);
    chk($sformatf("reg_%h", a), e, d);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wt(2);
    chk("flags", 16'h0000, fl);
    for (int i = 0; i < 5; i++) begin
      wr16(adr[i], 16'h0001);
      rchk(adr[i], 16'h0001);
      wr16(adr[i], 16'h0000);
      rchk(adr[i], 16'h0000);
      wcode(cod[i], 1'b1);
      rchk(adr[i], 16'h0001);
      wcode(cod[i], 1'b0);
      rchk(adr[i], 16'h0000);
    end
    rchk(16'hff30, 16'h0000);
    $display("codes and registers done");
    wr16(16'hff2e, 16'h0043);
    wr16(16'hff00, 16'h0001);
    wr16(16'hff02, 16'h0001);
    wt(4);
    chk("flags", 16'h000f, fl);
    wr16(16'hff2a, 16'h1000);
    wt(4);
    chk("flags", 16'h000b, fl);
    wr16(16'hff00, 16'h0000);
    wt(4);
    chk("flags", 16'h000d, fl);
    wr16(16'hff02, 16'h0000);
    wr16(16'hff2a, 16'h0000);
    wt(4);
    chk("flags", 16'h0000, fl);
    $display("flags and outputs done");
    wr16(16'hff2c, 16'h573b);
    wt(4);
    chk("flags", 16'h0000, fl);
    @(posedge clk);
    ctrl_in <= 4'he;
    wt(6);
    chk("flags", 16'h0009, fl);
    rchk(16'hff20, 16'h000e);
    wr16(16'hff2a, 16'h0001);
    wt(4);
    chk("flags", 16'h0000, fl);
    @(posedge clk);
    ctrl_in <= 4'hf;
    wt(6);
    chk("flags", 16'h0009, fl);
    rchk(16'hff20, 16'h000f);
    wr16(16'hff2a, 16'h0000);
    chk("clears", 16'h0005, 16'(n_clr));
    $display("control inputs done");
    wr16(16'hff26, 16'h0000);
    rd16(16'hff22, t0);
    wr16(16'hff0c, 16'h0001);
    wt(2000);
    wr16(16'hff0c, 16'h0000);
    rd16(16'hff22, v);
    rng("tally_up", v - t0, 16'h0009, 16'h000b);
    rd16(16'hff24, d0);
    wr16(16'hff0e, 16'h0001);
    wt(2000);
    wr16(16'hff0e, 16'h0000);
    rd16(16'hff24, v);
    rng("diff_down", d0 - v, 16'h0009, 16'h000b);
    wr16(16'hff26, 16'h0002);
    rd16(16'hff22, t0);
    wr16(16'hff0c, 16'h0001);
    wt(6000);
    wr16(16'hff0c, 16'h0000);
    rd16(16'hff22, v);
    rng("tally_ivl", v - t0, 16'h0009, 16'h000b);
    rd16(16'hff22, t0);
    wt(1000);
    rchk(16'hff22, t0);
    $display("trim done");
    wr16(16'hff28, 16'h0005);
    rd16(16'hff24, d0);
    wr16(16'hff0a, 16'h0001);
    rchk(16'hff24, d0);
    wr16(16'hff0a, 16'h0000);
    rchk(16'hff24, d0 + 16'h0005);
    rd16(16'hff22, t0);
    wr16(16'hff04, 16'h0001);
    rchk(16'hff24, 16'h0000);
    rchk(16'hff22, t0);
    wr16(16'hff04, 16'h0000);
    wr16(16'hff2a, 16'h0100);
    wr16(16'hff04, 16'h0001);
    rchk(16'hff24, 16'h0000);
    rchk(16'hff22, 16'h0000);
    wr16(16'hff04, 16'h0000);
    $display("offset and clear done");
    stop_test;
  end
endmodule // cid_tb
`default_nettype wire
